// file: tmr1_timer.sv
// timer 1: 8-bit up counter with double-buffered reload, event
// counting, buzzer and pwm, behind an ahb-lite slave
// assumes a single master and whole-word transfers
`default_nettype none
`include "tmr1_regs.svh"
// How it works
// RULE1 - overflow reloads counter from active reload; code reloads from reload_stage instead
// RULE2 - reload writes staged, applied at overflow
// RULE3 - software sets counter equal reload first
// RULE4 - software changes interval through reload register
// RULE5 - pwm forces reload; reload bit picks period
// RULE6 - period 256/64/32/16 from reload, buzzer bits
// RULE7 - software computes reload from boundary, interval
// RULE8 - external select counts event pin falling edges
// RULE9 - event mode overflows from max to zero; code loads reload_stage instead when the reload bit is set
// RULE10 - event mode blocks pin wake-up
// RULE11 - event mode blocks pin interrupt flag
// RULE12 - buzzer toggles pin at half overflow rate
// RULE13 - overflow still sets irq during buzzer
// RULE14 - buzzer off returns pin to gpio
// RULE15 - software keeps pwm off using buzzer
// RULE16 - pwm drives pin when enabled and running
// RULE17 - pwm high at start, low at match
// RULE18 - software clears counter before pwm start
// RULE19 - pwm changes apply at next reload
// RULE20 - pwm sets irq once per period
// RULE21 - pwm off returns pin to gpio
// RULE22 - overflow sets sticky irq flag
// RULE23 - clock bit selects cpu or fast prescale
// RULE24 - mode register layout, reset zero
// RULE25 - short periods compare low counter bits
// RULE26 - event pin synchronised before edge detect
module tmr1_timer
  import tmr1_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // event pin and its gpio functions
  input wire logic event_input_pin,
  input wire logic event_pin_fall_raw,
  output logic event_pin_wake_enable,
  output logic event_pin_irq_flag,
  // shared output pin
  input wire logic gpio_level,
  input wire logic gpio_oe,
  output tmr1_pkg::tmr1_pin_t shared_output_pin,
  // timer interrupt request
  output logic timer1_irq
);
  import tmr1_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    tmr1_mode_t mode;
    logic [7:0] count;
    logic [7:0] reload_stage;
    logic [7:0] reload_active;
    logic irq_flag;
    logic irq_enable;
    logic fast_clock_select;
    logic pin_irq;
    logic buzz;
    logic pwm;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    tmr1_pin_t pin;
    logic irq_out;
    logic wake_en;
  } tmr1_state_t;
  tmr1_state_t state_reg, state_next;

  logic pre_tick;
  logic fall;
  logic step;
  logic [7:0] mask;
  logic [7:0] cnt_m;
  logic ovf;
  logic ev_mode;
  logic pwm_on;

  function automatic logic [7:0] period_mask(input tmr1_mode_t m);
    tmr1_period_t p;
    p = tmr1_period_t'({m.reload_enable, m.buzzer_enable});
    period_mask = 8'hff;
    if (m.pwm_output_enable && !m.external_source_select) begin // [RULE6]
      case (p)
        TMR1_P64: period_mask = 8'h3f;
        TMR1_P32: period_mask = 8'h1f;
        TMR1_P16: period_mask = 8'h0f;
        default: period_mask = 8'hff;
      endcase
    end
  endfunction : period_mask

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  tmr1_prescaler u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(state_reg.mode.timer_enable),
    .fast_clock_select(state_reg.fast_clock_select),
    .prescaler_select(state_reg.mode.prescaler_select),
    .tick(pre_tick)
  );

  tmr1_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(event_input_pin),
    .fall(fall)
  );

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  always_comb begin
    ev_mode = state_reg.mode.external_source_select;
    pwm_on = state_reg.mode.pwm_output_enable;
    step = state_reg.mode.timer_enable & (ev_mode ? fall : pre_tick); // [RULE8]
    mask = period_mask(state_reg.mode);
    cnt_m = state_reg.count & mask; // [RULE25]
    ovf = step && (cnt_m == mask); // [RULE9]
  end

  always_comb begin
    state_next = state_reg;
    // bus data phase write, address captured last cycle
    if (state_reg.wr_pend) begin
      state_next.wr_pend = 1'b0;
      if (state_reg.wr_addr == `TMR1_ADDR_MODE) begin
        state_next.mode = tmr1_mode_t'(hwdata[7:0]); // [RULE24]
      end else if (state_reg.wr_addr == `TMR1_ADDR_COUNT) begin
        state_next.count = hwdata[7:0];
      end else if (state_reg.wr_addr == `TMR1_ADDR_RELOAD) begin
        state_next.reload_stage = hwdata[7:0]; // [RULE2]
      end else if (state_reg.wr_addr == `TMR1_ADDR_CTRL) begin
        state_next.irq_enable = hwdata[`TMR1_CTRL_IEN];
        state_next.fast_clock_select = hwdata[`TMR1_CTRL_FAST];
        if (!hwdata[`TMR1_CTRL_IRQ]) begin
          state_next.irq_flag = 1'b0;
        end
        if (!hwdata[`TMR1_CTRL_PINIRQ]) begin
          state_next.pin_irq = 1'b0;
        end
      end
    end
    // counter step; a same-cycle count write loses to the timer
    if (step) begin
      if (ovf) begin
        state_next.reload_active = state_reg.reload_stage; // [RULE2]
        state_next.irq_flag = 1'b1; // [RULE22] [RULE13] [RULE20]
        state_next.buzz = ~state_reg.buzz; // [RULE12]
        state_next.pwm = 1'b1; // [RULE17]
        if (pwm_on) begin
          // low bits restart at zero: duty must not shorten the period
          state_next.count = state_reg.reload_stage & ~mask; // [RULE5] [RULE19]
        end else if (state_reg.mode.reload_enable) begin
          // reload from the staged value so a new period starts clean
          state_next.count = state_reg.reload_stage; // [RULE1]
        end else begin
          state_next.count = (state_reg.count & ~mask);
        end
      end else begin
        state_next.count = state_reg.count + 8'h01;
        if (((cnt_m + 8'h01) & mask) == (state_reg.reload_active & mask)) begin
          state_next.pwm = 1'b0; // [RULE17] [RULE25]
        end
      end
    end
    if (!(state_reg.mode.timer_enable && pwm_on)) begin
      state_next.pwm = 1'b1;
    end
    // event pin gpio interrupt, suppressed in event mode
    if (ev_mode) begin
      state_next.pin_irq = 1'b0; // [RULE11]
    end else if (event_pin_fall_raw) begin
      state_next.pin_irq = 1'b1;
    end
    state_next.wake_en = ~ev_mode; // [RULE10]
    // shared pin mux: pwm wins over buzzer
    if (pwm_on && state_reg.mode.timer_enable) begin
      state_next.pin = '{level: state_next.pwm, oe: 1'b1}; // [RULE16]
    end else if (state_reg.mode.buzzer_enable && !pwm_on) begin
      state_next.pin = '{level: state_next.buzz, oe: 1'b1}; // [RULE12]
    end else begin
      // gpio kept outside, so it is restored as it was
      state_next.pin = '{level: gpio_level, oe: gpio_oe}; // [RULE14] [RULE21]
    end
    state_next.irq_out = state_next.irq_flag & state_next.irq_enable; // [RULE13]
    // bus address phase
    if (hsel && hready && htrans[1]) begin
      state_next.wr_pend = hwrite;
      state_next.wr_addr = haddr;
      state_next.rdata = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr == `TMR1_ADDR_MODE) begin
          state_next.rdata = {24'h00_0000, state_reg.mode};
        end else if (haddr == `TMR1_ADDR_COUNT) begin
          state_next.rdata = {24'h00_0000, state_reg.count};
        end else if (haddr == `TMR1_ADDR_CTRL) begin
          state_next.rdata = {28'h000_0000, state_reg.pin_irq,
            state_reg.fast_clock_select, state_reg.irq_enable,
            state_reg.irq_flag};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign event_pin_wake_enable = state_reg.wake_en;
  assign event_pin_irq_flag = state_reg.pin_irq;
  assign shared_output_pin = state_reg.pin;
  assign timer1_irq = state_reg.irq_out;
endmodule : tmr1_timer
`default_nettype wire

// file: tmr1_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit ahb-lite slave, one word per register
`ifndef TMR1_REGS_SVH
`define TMR1_REGS_SVH
// printed offsets are not all multiples of four: kept as indices
`define TMR1_IDX_MODE 8'hdc
`define TMR1_IDX_COUNT 8'hdd
`define TMR1_IDX_RELOAD 8'hde
`define TMR1_IDX_CTRL 8'hdf
`define TMR1_ADDR_MODE 12'h370
`define TMR1_ADDR_COUNT 12'h374
`define TMR1_ADDR_RELOAD 12'h378
`define TMR1_ADDR_CTRL 12'h37c
// mode register fields
`define TMR1_MODE_PWM 0
`define TMR1_MODE_BUZ 1
`define TMR1_MODE_RLD 2
`define TMR1_MODE_EXT 3
`define TMR1_MODE_PRE_LO 4
`define TMR1_MODE_ENB 7
// control/status register fields
`define TMR1_CTRL_IRQ 0
`define TMR1_CTRL_IEN 1
`define TMR1_CTRL_FAST 2
`define TMR1_CTRL_PINIRQ 3
`define TMR1_RESET_BYTE 8'h00
// fcpu is hclk divided by this
`define TMR1_FCPU_DIV 4
`endif

// file: tmr1_pkg.sv
// types shared by the timer files
// assumes tmr1_regs.svh holds the numbers
`default_nettype none
package tmr1_pkg;
  typedef struct packed {
    logic timer_enable;
    logic [2:0] prescaler_select;
    logic external_source_select;
    logic reload_enable;
    logic buzzer_enable;
    logic pwm_output_enable;
  } tmr1_mode_t;
  typedef struct packed {
    logic level;
    logic oe;
  } tmr1_pin_t;
  typedef enum logic [1:0] {
    TMR1_P256,
    TMR1_P64,
    TMR1_P32,
    TMR1_P16
  } tmr1_period_t;
endpackage : tmr1_pkg
`default_nettype wire

// file: tmr1_prescaler.sv
// prescaler: one-cycle tick for the counter's internal clock
// assumes fcpu is hclk/4 and the fast oscillator is hclk
`default_nettype none
`include "tmr1_regs.svh"
module tmr1_prescaler #(
  parameter int FCPU_DIV = `TMR1_FCPU_DIV
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // selection
  input wire logic run,
  input wire logic fast_clock_select,
  input wire logic [2:0] prescaler_select,
  // tick
  output logic tick
);
  typedef struct packed {
    logic [10:0] div;
    logic tick;
  } tmr1_pre_state_t;
  tmr1_pre_state_t state_reg, state_next;
  logic [10:0] limit;

  // fcpu: 256 >> rate, times the cpu divider; fast: 128 >> rate
  // slowest fcpu rate needs 1024 hclk: ten bits would wrap to zero
  always_comb begin
    if (fast_clock_select) begin
      limit = 11'(11'h080 >> prescaler_select);
    end else begin
      limit = 11'((11'h100 >> prescaler_select) * FCPU_DIV);
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!run) begin
      state_next.div = 11'h000;
    end else if (state_reg.div + 11'h001 >= limit) begin // [RULE23]
      state_next.div = 11'h000;
      state_next.tick = 1'b1;
    end else begin
      state_next.div = state_reg.div + 11'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule : tmr1_prescaler
`default_nettype wire

// file: tmr1_edge_detect.sv
// falling-edge detector for the asynchronous event pin
// assumes nothing of the pin's phase
`default_nettype none
module tmr1_edge_detect (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin
  input wire logic pin,
  // falling edge seen
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fall;
  } tmr1_edge_state_t;
  tmr1_edge_state_t state_reg, state_next;

  // s1 feeds only s2; edge logic looks at s2/s3
  always_comb begin
    state_next = state_reg;
    state_next.s1 = pin; // [RULE26]
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.fall = state_reg.s3 & ~state_reg.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // stages at the pin's idle high, no edge pending after reset
      state_reg <= 4'he;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fall = state_reg.fall;
endmodule : tmr1_edge_detect
`default_nettype wire

// file: tmr1_timer_sva.sv
// checker: bus answers, pin hand-over, event-mode gating
// assumes binding to tmr1_timer; mode/ctrl mirrored from writes
`default_nettype none
module tmr1_timer_sva (
  // clock, reset, bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic event_pin_wake_enable,
  input wire logic event_pin_irq_flag,
  input wire logic gpio_level,
  input wire logic gpio_oe,
  input wire tmr1_pkg::tmr1_pin_t shared_output_pin,
  input wire logic timer1_irq
);
  logic pv, pw, ien;
  logic [11:0] pa;
  logic [7:0] md;
  logic [2:0] gp, bz;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // software view of mode and ctrl
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pv, pw, pa, md, ien, bz} <= '0;
      gp <= 3'h7; // pin register not yet loaded after reset
    end else begin
      pv <= hsel && hready && htrans[1];
      pw <= hwrite;
      pa <= haddr;
      if (pv && pw && pa == 12'h370) md <= hwdata[7:0];
      if (pv && pw && pa == 12'h37c) ien <= hwdata[1];
      gp <= {gp[1:0], md[0] | md[1]};
      bz <= {bz[1:0], md[7] & md[1] & !md[0]};
    end
  end
  AST_WAKE_OFF: assert property (
    md[3] && $past(md[3]) |-> !event_pin_wake_enable) else $error("wake on");
  AST_PIN_IRQ_OFF: assert property (
    md[3] && $past(md[3]) |-> !event_pin_irq_flag) else $error("pin irq");
  AST_GPIO_PASS: assert property (
    !(md[0] | md[1]) && gp == 3'h0 |-> shared_output_pin ==
    {$past(gpio_level), $past(gpio_oe)}) else $error("pin not gpio");
  AST_BUZ_DRIVE: assert property (
    bz == 3'h7 |-> shared_output_pin.oe) else $error("buzzer not driven");
  AST_RELOAD_WO: assert property (
    pv && !pw && pa == 12'h378 |-> hrdata == 32'h0) else $error("reload");
  AST_MODE_READ: assert property (
    pv && !pw && pa == 12'h370 |-> hrdata == {24'h0, md}) else $error("mode");
  AST_UPPER_ZERO: assert property (
    pv && !pw |-> hrdata[31:8] == 24'h0) else $error("upper bits");
  AST_IRQ_GATE: assert property (
    !ien && !$past(ien) |-> !timer1_irq) else $error("irq not gated");
endmodule : tmr1_timer_sva
bind tmr1_timer tmr1_timer_sva u_sva (.*);
`default_nettype wire

// file: tmr1_evt_src.sv
// event source on the event input pin, idle high by pull-up
// assumes go is a one-cycle request from the bench
`default_nettype none
module tmr1_evt_src (
  // clock, reset, request
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  // pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] n;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n <= 4'h0;
      pin <= 1'b1;
    end else begin
      n <= go ? 4'hc : n - 4'(n != 4'h0);
      // 3 ns skew: edge lands 3 ns after hclk rises, clear of the clock edge
      pin <= #3 !(go || n > 4'h6);
    end
  end
endmodule : tmr1_evt_src
`default_nettype wire

// file: tb.sv
// bench: registers, event counting, buzzer, pwm periods
// assumes tmr1_timer, its bound checker and tmr1_evt_src
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, go;
  logic evt, fall, wake, pirq, gl, goe, irq, lv;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  tmr1_pkg::tmr1_pin_t pin;
  int err_total = 0, checked = 0, cyc = 0, n, t0;
  logic [11:0] ra [5] = '{12'h370, 12'h374, 12'h378, 12'h37c, 12'h380};
  logic [7:0] rw [5] = '{8'h55, 8'ha5, 8'h3c, 8'h06, 8'hff};
  logic [7:0] re [5] = '{8'h55, 8'ha5, 8'h00, 8'h06, 8'h00};
  logic [7:0] pm [4] = '{8'hf1, 8'hf3, 8'hf5, 8'hf7};
  int pp [4] = '{256, 64, 32, 16};
  assign hready = hreadyout;
  tmr1_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .event_input_pin(evt),
    .event_pin_fall_raw(fall), .event_pin_wake_enable(wake),
    .event_pin_irq_flag(pirq), .gpio_level(gl), .gpio_oe(goe),
    .shared_output_pin(pin), .timer1_irq(irq));
  tmr1_evt_src u_src (.hclk(hclk), .hresetn(hresetn), .go(go), .pin(evt));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = !hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic ck(input string s, input logic [31:0] e, v);
    checked++;
    if (v !== e) begin
      $display("Error %s expected %h seen %h", s, e, v);
      err_total++;
    end
  endtask : ck
  task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic pulse();
    @(posedge hclk) go <= 1'b1;
    @(posedge hclk) go <= 1'b0;
    repeat (14) @(negedge hclk);
  endtask : pulse
  // two edges first: a flag cleared just before must land
  task automatic wirq();
    repeat (2) @(negedge hclk);
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      @(negedge hclk);
      n++;
    end
  endtask : wirq
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    {hresetn, hsel, hwrite, go, fall, haddr, htrans, hwdata} = '0;
    gl = 1'b1;
    goe = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(ra[i], 1'b0, 32'h0);
      ck("reset value", 32'h0, q);
    end
    for (int i = 0; i < 5; i++) begin
      bus(ra[i], 1'b1, {24'h0, rw[i]});
      bus(ra[i], 1'b0, 32'h0);
      ck("register", {24'h0, re[i]}, q);
    end
    $display("register test done");
    bus(12'h370, 1'b1, 32'h0);
    bus(12'h374, 1'b1, 32'hfe);
    bus(12'h378, 1'b1, 32'hfe);
    bus(12'h37c, 1'b1, 32'h02);
    bus(12'h370, 1'b1, 32'h8c);
    fall <= 1'b1;
    @(posedge hclk) fall <= 1'b0;
    bus(12'h378, 1'b1, 32'h10);
    pulse();
    ck("wake enable", 32'h0, wake);
    ck("pin irq", 32'h0, pirq);
    ck("irq early", 32'h0, irq);
    bus(12'h374, 1'b0, 32'h0);
    ck("count", 32'hff, q);
    pulse();
    ck("irq at wrap", 32'h1, irq);
    pulse();
    ck("irq kept", 32'h1, irq);
    bus(12'h374, 1'b0, 32'h0);
    ck("reloaded", 32'h11, q);
    $display("event test done");
    bus(12'h370, 1'b1, 32'h0);
    bus(12'h374, 1'b1, 32'hf0);
    bus(12'h378, 1'b1, 32'hf0);
    bus(12'h37c, 1'b1, 32'h06);
    bus(12'h370, 1'b1, 32'hf6);
    repeat (8) @(negedge hclk);
    ck("buzzer drive", 32'h1, pin.oe);
    n = 0;
    lv = pin.level;
    for (int i = 0; i < 160; i++) begin
      @(negedge hclk);
      if (pin.level !== lv) n++;
      lv = pin.level;
    end
    ck("buzzer toggles", 32'h1, n >= 9 && n <= 11);
    ck("irq in buzzer", 32'h1, irq);
    bus(12'h370, 1'b1, 32'hf4);
    {gl, goe} <= 2'b01;
    bus(12'h37c, 1'b1, 32'h06);
    wirq();
    ck("pin to gpio", 32'h1, pin);
    ck("timer runs", 32'h1, irq);
    $display("buzzer test done");
    for (int i = 0; i < 4; i++) begin
      bus(12'h370, 1'b1, 32'h0);
      bus(12'h374, 1'b1, 32'h0);
      bus(12'h378, 1'b1, 32'(8'(256 - pp[i]) | 8'h05));
      bus(12'h37c, 1'b1, 32'h06);
      bus(12'h370, 1'b1, {24'h0, pm[i]});
      wirq();
      t0 = cyc;
      bus(12'h37c, 1'b1, 32'h06);
      wirq();
      ck("pwm period", pp[i], cyc - t0);
      ck("pwm drive", 32'h1, pin.oe);
      n = 0;
      repeat (pp[i]) begin
        @(negedge hclk);
        n += pin.level;
      end
      ck("pwm duty", 32'h5, n);
    end
    bus(12'h370, 1'b1, 32'hf4);
    repeat (4) @(negedge hclk);
    ck("pwm off gpio", 32'h1, pin);
    $display("pwm test done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
